// ===== design/bmc_pkg.sv
package bmc_pkg;

  // byte addresses on the register port (window 0; the window select at 7e/7f answers in every window)
  localparam logic [6:0] BMC_ADDR_BURST_LO = 7'h00;
  localparam logic [6:0] BMC_ADDR_BURST_HI = 7'h01;
  localparam logic [6:0] BMC_ADDR_MODE_LO = 7'h02;
  localparam logic [6:0] BMC_ADDR_MODE_HI = 7'h03;
  localparam logic [6:0] BMC_ADDR_WIN_LO = 7'h7e;
  localparam logic [6:0] BMC_ADDR_WIN_HI = 7'h7f;

  // burst trigger value
  localparam logic [7:0] BMC_BURST_GO = 8'h00;

  // field positions inside the operating_state_control word
  localparam int BMC_STAT_LSB = 10;
  localparam int BMC_CMD_LSB = 8;
  // command field only, position inside the high byte
  localparam int BMC_CMD_HB_LSB = 0;

  // operating state encodings
  localparam logic [1:0] BMC_STAT_SAMPLING = 2'h0;
  localparam logic [1:0] BMC_STAT_CONFIG = 2'h1;

  // state change commands
  localparam logic [1:0] BMC_CMD_DONE = 2'h0;
  localparam logic [1:0] BMC_CMD_TO_SAMPLING = 2'h1;
  localparam logic [1:0] BMC_CMD_TO_CONFIG = 2'h2;
  localparam logic [1:0] BMC_CMD_UNUSED = 2'h3;

  // reset values
  localparam logic [1:0] BMC_STAT_RESET = BMC_STAT_CONFIG;
  localparam logic [7:0] BMC_WIN_RESET = 8'h00;
  localparam logic [7:0] BMC_WIN_ZERO = 8'h00;

  // cycles a mode transition takes
  localparam int BMC_TRANS_CYCLES = 4;

  typedef enum logic [0:0]
  {
    BMC_ST_IDLE = 1'b0,
    BMC_ST_TRANS = 1'b1
  } bmc_state_e;

  typedef struct packed
  {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } bmc_req_s;

  typedef struct packed
  {
    logic start;
    logic [15:0] sel;
  } bmc_burst_s;

endpackage

// ===== design/bmc_top.sv
`timescale 1ns/1ps
// Overview of operation
// - write 0x00 to trigger byte starts burst, only in window 0 while sampling
// - burst content follows the content selection register
// - bits 11:10 report sampling or configuration
// - bits 9:8 are command; 00 means complete
// - command 01 enters sampling, then clears itself
// - command 10 enters configuration, then clears itself
module bmc_top
#(
  parameter int TRANS_CYC = bmc_pkg::BMC_TRANS_CYCLES
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register access from the link interpreter
  input wire bmc_pkg::bmc_req_s req,
  output logic [15:0] rdata,
  output logic rvalid,
  // burst engine
  input wire logic [15:0] burst_sel_in,
  output bmc_pkg::bmc_burst_s burst,
  // mode to the sampling core
  output logic sampling_on
);
  import bmc_pkg::*;

  localparam int TRANS_MAX = TRANS_CYC + 1;

  bmc_state_e state_r, state_nxt;
  logic [1:0] stat_r, stat_nxt;
  logic [1:0] cmd_r, cmd_nxt;
  logic [1:0] target_r, target_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [7:0] win_r, win_nxt;
  logic [15:0] rdata_nxt;
  logic rvalid_nxt;
  bmc_burst_s burst_nxt;
  logic win0;
  logic cmd_wr;
  logic [1:0] cmd_val;

  assign win0 = (win_r == BMC_WIN_ZERO);
  assign cmd_wr = req.wr && win0 && (req.addr == BMC_ADDR_MODE_HI);
  assign cmd_val = req.wdata[BMC_CMD_HB_LSB +: 2];

  // window select and burst trigger
  always_comb
  begin
    win_nxt = win_r;
    burst_nxt.start = 1'b0;
    burst_nxt.sel = burst.sel;
    if (req.wr && (req.addr == BMC_ADDR_WIN_HI))
    begin
      win_nxt = req.wdata;
    end
    else if (req.wr && win0 && (req.addr == BMC_ADDR_BURST_LO) && (req.wdata == BMC_BURST_GO)
             && (stat_r == BMC_STAT_SAMPLING))
    begin
      burst_nxt.start = 1'b1;
      burst_nxt.sel = burst_sel_in;
    end
  end

  // mode command interpreter
  always_comb
  begin
    state_nxt = state_r;
    stat_nxt = stat_r;
    cmd_nxt = cmd_r;
    target_nxt = target_r;
    cnt_nxt = cnt_r;
    case (state_r)
      BMC_ST_IDLE:
      begin
        if (cmd_wr && (cmd_val == BMC_CMD_TO_SAMPLING || cmd_val == BMC_CMD_TO_CONFIG))
        begin
          cmd_nxt = cmd_val;
          target_nxt = (cmd_val == BMC_CMD_TO_SAMPLING) ? BMC_STAT_SAMPLING : BMC_STAT_CONFIG;
          cnt_nxt = 16'(TRANS_CYC - 1);
          state_nxt = BMC_ST_TRANS;
        end
      end
      BMC_ST_TRANS:
      begin
        if (cnt_r == 16'h0000)
        begin
          stat_nxt = target_r;
          cmd_nxt = BMC_CMD_DONE;
          state_nxt = BMC_ST_IDLE;
        end
        else
        begin
          cnt_nxt = cnt_r - 16'h0001;
        end
      end
      default:
      begin
        state_nxt = BMC_ST_IDLE;
      end
    endcase
  end

  // read path
  always_comb
  begin
    rvalid_nxt = req.rd;
    rdata_nxt = 16'h0000;
    if (req.rd && (req.addr == BMC_ADDR_WIN_HI || req.addr == BMC_ADDR_WIN_LO))
    begin
      rdata_nxt = {win_r, 8'h00};
    end
    else if (req.rd && win0 && (req.addr == BMC_ADDR_MODE_LO || req.addr == BMC_ADDR_MODE_HI))
    begin
      rdata_nxt[BMC_STAT_LSB +: 2] = stat_r;
      rdata_nxt[BMC_CMD_LSB +: 2] = cmd_r;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_r <= BMC_ST_IDLE;
      stat_r <= BMC_STAT_RESET;
      cmd_r <= BMC_CMD_DONE;
      target_r <= BMC_STAT_RESET;
      cnt_r <= 16'h0000;
      win_r <= BMC_WIN_RESET;
      rdata <= 16'h0000;
      rvalid <= 1'b0;
      burst <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      stat_r <= stat_nxt;
      cmd_r <= cmd_nxt;
      target_r <= target_nxt;
      cnt_r <= cnt_nxt;
      win_r <= win_nxt;
      rdata <= rdata_nxt;
      rvalid <= rvalid_nxt;
      burst <= burst_nxt;
    end
  end

  assign sampling_on = (stat_r == BMC_STAT_SAMPLING);

  // checks
  sequence burst_req_q;
    req.wr && win0 && (req.addr == BMC_ADDR_BURST_LO) && (req.wdata == BMC_BURST_GO) && sampling_on;
  endsequence

  sequence go_samp_q;
    cmd_wr && (cmd_val == BMC_CMD_TO_SAMPLING) && (state_r == BMC_ST_IDLE);
  endsequence

  sequence go_cfg_q;
    cmd_wr && (cmd_val == BMC_CMD_TO_CONFIG) && (state_r == BMC_ST_IDLE);
  endsequence

  burst_start_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    burst_req_q |=> burst.start)
    else $error("burst trigger did not start a burst");

  burst_only_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    burst.start |-> $past(req.wr) && $past(req.wdata) == BMC_BURST_GO && $past(sampling_on)
      && $past(req.addr) == BMC_ADDR_BURST_LO && $past(win0))
    else $error("burst started without a valid trigger");

  burst_sel_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    burst_req_q |=> burst.sel == $past(burst_sel_in))
    else $error("burst content selection not captured");

  stat_code_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !stat_r[1])
    else $error("operating state shows unused code");

  stat_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    req.rd && win0 && (req.addr == BMC_ADDR_MODE_LO || req.addr == BMC_ADDR_MODE_HI)
      |=> rvalid && rdata[BMC_CMD_LSB +: 4] == $past({stat_r, cmd_r}))
    else $error("mode word read back wrong");

  cmd_unused_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cmd_wr && cmd_val == BMC_CMD_UNUSED && state_r == BMC_ST_IDLE |=> cmd_r == BMC_CMD_DONE && $stable(stat_r))
    else $error("unused command acted on");

  to_samp_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    go_samp_q |=> cmd_r == BMC_CMD_TO_SAMPLING ##[1:TRANS_MAX] (cmd_r == BMC_CMD_DONE && sampling_on))
    else $error("sampling transition did not complete");

  to_cfg_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    go_cfg_q |=> cmd_r == BMC_CMD_TO_CONFIG ##[1:TRANS_MAX] (cmd_r == BMC_CMD_DONE && stat_r == BMC_STAT_CONFIG))
    else $error("configuration transition did not complete");

  cmd_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state_r == BMC_ST_TRANS && cnt_r != 16'h0000 |=> $stable(stat_r) && $stable(cmd_r))
    else $error("mode changed before transition finished");

  cmd_busy_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cmd_wr && state_r == BMC_ST_TRANS |=> $stable(target_r) && (cmd_r == $past(cmd_r) || cmd_r == BMC_CMD_DONE))
    else $error("command taken during a transition");

  mode_done_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state_r == BMC_ST_IDLE |-> cmd_r == BMC_CMD_DONE)
    else $error("command field not complete while idle");

  // any write while another window is selected and no transition runs
  sequence hidden_wr_q;
    req.wr && !win0 && (state_r == BMC_ST_IDLE);
  endsequence

  hidden_wr_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    hidden_wr_q |=> !burst.start && state_r == BMC_ST_IDLE)
    else $error("write acted on while window hidden");

  sel_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !burst.start |-> $stable(burst.sel))
    else $error("burst selection changed without a start");

  rvalid_pulse_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    req.rd |=> rvalid)
    else $error("read not answered");

  rvalid_only_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !req.rd |=> !rvalid)
    else $error("read answer without a read");

endmodule

// ===== bench/bmc_host.sv
`timescale 1ns/1ps
module bmc_host
import bmc_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // register port
  output bmc_req_s req,
  input wire logic [15:0] rdata,
  input wire logic rvalid
);
  initial req = '0;
  // released lines show the inverse of the last value
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    req <= '{1'b1, 1'b0, a, d};
    @(negedge clk_sys);
    req <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  // answer comes one cycle after the read edge
  task automatic rd(input logic [6:0] a, output logic [15:0] q, output bit ok);
    @(negedge clk_sys);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_sys);
    req <= '{1'b0, 1'b0, ~a, 8'hff};
    ok = rvalid === 1'b1;
    q = rdata;
  endtask
  task automatic poll(output bit ok);
    logic [15:0] q;
    bit v;
    ok = 0;
    for (int n = 0; n < 20 && !ok; n++)
    begin
      rd(BMC_ADDR_MODE_LO, q, v);
      ok = v && q[9:8] === BMC_CMD_DONE;
    end
  endtask
endmodule

// ===== bench/burst_and_mode_control_tb.sv
`timescale 1ns/1ps
module burst_and_mode_control_tb;
import bmc_pkg::*;
  logic clk_sys, sys_rst, rvalid, sampling_on;
  logic [15:0] sel, q, rdata;
  logic [7:0] w;
  bmc_req_s req;
  bmc_burst_s burst;
  int failures, total_checks, seed;
  bit ok;
  bmc_top #(.TRANS_CYC(4)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .req(req), .rdata(rdata),
    .rvalid(rvalid), .burst_sel_in(sel), .burst(burst), .sampling_on(sampling_on));
  bmc_host host (.clk_sys(clk_sys), .req(req), .rdata(rdata), .rvalid(rvalid));
  initial
  begin
    clk_sys = 0;
    forever #10 clk_sys = ~clk_sys;
  end
  function automatic logic [15:0] mw(input logic [1:0] s, input logic [1:0] c);
    return {4'h0, s, c, 8'h00};
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (s !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [15:0] e);
    host.rd(a, q, ok);
    chk("rvalid", 16'h1, {15'h0, ok});
    chk("rdata", e, q);
  endtask
  // burst write with fresh selection, then start must drop
  task automatic go(input logic [7:0] d, input logic e);
    logic [15:0] s;
    logic [15:0] p;
    s = $random(seed);
    p = burst.sel;
    sel = s;
    host.wr(BMC_ADDR_BURST_LO, d);
    sel = ~s;
    chk("start", {15'h0, e}, {15'h0, burst.start});
    if (e)
      chk("sel", s, burst.sel);
    else
      chk("sel_hold", p, burst.sel);
    @(negedge clk_sys);
    chk("start_end", 16'h0, {15'h0, burst.start});
  endtask
  task automatic setmode(input logic [1:0] c, input logic [1:0] o, input logic [1:0] n);
    host.wr(BMC_ADDR_MODE_HI, {6'h0, c});
    host.wr(BMC_ADDR_MODE_HI, {6'h0, ~c});
    rdchk(BMC_ADDR_MODE_LO, mw(o, c));
    host.poll(ok);
    if (!ok)
    begin
      failures++;
      complete_run();
    end
    rdchk(BMC_ADDR_MODE_LO, mw(n, BMC_CMD_DONE));
    chk("sampling_on", {15'h0, n == BMC_STAT_SAMPLING}, {15'h0, sampling_on});
  endtask
  initial
  begin
    seed = 94;
    failures = 0;
    total_checks = 0;
    sys_rst = 1;
    sel = 0;
    repeat (4) @(negedge clk_sys);
    sys_rst = 0;
    chk("sampling_on", 16'h0, {15'h0, sampling_on});
    rdchk(BMC_ADDR_MODE_HI, mw(BMC_STAT_CONFIG, BMC_CMD_DONE));
    go(BMC_BURST_GO, 0);
    host.wr(BMC_ADDR_MODE_HI, {6'h0, BMC_CMD_UNUSED});
    rdchk(BMC_ADDR_MODE_LO, mw(BMC_STAT_CONFIG, BMC_CMD_DONE));
    setmode(BMC_CMD_TO_SAMPLING, BMC_STAT_CONFIG, BMC_STAT_SAMPLING);
    repeat (3) go(BMC_BURST_GO, 1);
    go(8'h01 | $random(seed), 0);
    w = 8'h01 | $random(seed);
    host.wr(BMC_ADDR_WIN_HI, w);
    host.wr(BMC_ADDR_MODE_HI, {6'h0, BMC_CMD_TO_CONFIG});
    rdchk(BMC_ADDR_WIN_HI, {w, 8'h00});
    host.wr(BMC_ADDR_WIN_HI, BMC_WIN_ZERO);
    rdchk(BMC_ADDR_MODE_LO, mw(BMC_STAT_SAMPLING, BMC_CMD_DONE));
    setmode(BMC_CMD_TO_CONFIG, BMC_STAT_SAMPLING, BMC_STAT_CONFIG);
    go(BMC_BURST_GO, 0);
    rdchk(7'h40, 16'h0000);
    complete_run();
  end
endmodule
